//--- rtcs_defs.svh
`ifndef RTCS_DEFS_SVH
`define RTCS_DEFS_SVH

// register indices; byte address is four times the index
`define RTCS_IDX_CTRL1       8'h42
`define RTCS_IDX_CTRL2       8'h43
`define RTCS_IDX_FLAGS       8'h44
`define RTCS_IDX_ALM_MIN     8'h45
`define RTCS_IDX_ALM_HOUR    8'h46
`define RTCS_IDX_SEC         8'h47
`define RTCS_IDX_MIN         8'h48
`define RTCS_IDX_HOUR        8'h49
`define RTCS_IDX_DAY         8'h4A
`define RTCS_IDX_CHR         8'h4E

// clock_control_two fields
`define RTCS_C2_CLR          7
`define RTCS_C2_STOPWATCH_ENABLE         6
`define RTCS_C2_MODE         5

// clock_event_flags bit positions
`define RTCS_F_ALM           7
`define RTCS_F_CHR           6
`define RTCS_F_DAY           5
`define RTCS_F_HOUR          4
`define RTCS_F_MIN           3
`define RTCS_F_SEC           2
`define RTCS_F_HALF          1
`define RTCS_F_QUARTER       0

// reference edges per quarter second for each frequency select
`define RTCS_Q_32768         15'h2000
`define RTCS_Q_32000         15'h1F40
`define RTCS_Q_38400         15'h2580
`define RTCS_Q_64000         15'h3E80
`define RTCS_Q_76800         15'h4B00
// reference edges per stopwatch tick (128 Hz or 100 Hz)
`define RTCS_C_32768         10'h100
`define RTCS_C_32000         10'h140
`define RTCS_C_38400         10'h180
`define RTCS_C_64000         10'h280
`define RTCS_C_76800         10'h300
`define RTCS_RAW_WRAP_128    7'h7F
`define RTCS_RAW_WRAP_100    7'h63

`define RTCS_SEC_MAX         6'h3B
`define RTCS_MIN_MAX         6'h3B
`define RTCS_HOUR_MAX        5'h17
`define RTCS_DAY_MAX         5'h1F
`define RTCS_DAY_RESET       5'h01
`define RTCS_CHR_MAX         7'h63

`endif

//--- rtcs_pkg.sv
package rtcs_pkg;

  typedef struct packed {
    logic        refSync1;
    logic        refSync2;
    logic        refPrev;
    logic [14:0] prescale;
    logic [9:0]  chrDiv;
    logic [1:0]  quarter;
    logic [6:0]  chrRaw;
    logic [6:0]  chrData;
    logic [5:0]  sec;
    logic [5:0]  min;
    logic [4:0]  hour;
    logic [4:0]  day;
    logic [7:0]  almMin;
    logic [7:0]  almHour;
    logic        almHit;
    logic [7:0]  irqEn;
    logic [7:0]  flags;
    logic [7:0]  armed;
    logic        modEn;
    logic        chrEn;
    logic [2:0]  freqSel;
    logic        freqLocked;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        irq;
  } rtcs_state_t;

endpackage : rtcs_pkg

//--- rtcs_top.sv
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`include "rtcs_defs.svh"

// Overview of operation
// - writing one to stopwatch_clear zeroes the stopwatch, nothing else
// - stopwatch_clear is self clearing and always reads zero
// - stopwatch advances each hundredth second when enabled, else holds
// - module enable gates all counting; reset clears enables and clear
// - frequency select accepts only the first write after reset
// - frequency select picks the divider set for the reference clock
// - interrupt request when any flag is set with its enable set
// - alarm flag sets when hour and minute equal the alarm values
// - alarm flag clears on status read then alarm hour read
// - stopwatch flag sets each tick; clears via status then data read
// - day flag sets on day increment; clears via status then day read
// - hour flag sets on hour increment; clears via status then hour read
// - minute flag sets per minute; clears via status then minute read
// - second flag sets per second; clears via status then second read
// - half second flag; clears via status then stopwatch data read
// - quarter second flag; clears via status then stopwatch data read
// - alarm registers take any value; out of range never matches
// - second register reads live; writes load the counter
// - seconds wrap after 59; writes above 59 are ignored
// - minute register reads live; writes load the counter
// - minutes wrap after 59; writes above 59 are ignored
// - stopwatch data wraps to zero after 99
// - at 32.768 kHz stopwatch ticks 128 Hz, converted to hundredths
// - hours wrap after 23 and carry into the day counter
module rtcs_top
  import rtcs_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // reference oscillator pin
  input  wire logic        oscillatorRefClock,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // interrupt request
  output logic             irq
);

  rtcs_state_t st;
  rtcs_state_t next_st;

  logic       apbFirst;
  logic       apbDone;
  logic       wrDone;
  logic       rdDone;
  logic       refEdge;
  logic       qTick;
  logic       cTick;
  logic       secTick;
  logic       minTick;
  logic       hourTick;
  logic       dayTick;
  logic       almMatch;
  logic [7:0] setMask;
  logic [7:0] clrMask;
  logic [7:0] wr8;

  function automatic logic isReg(input logic [11:0] a, input logic [7:0] idx);
    isReg = (a[1:0] == 2'h0) && (a[11:2] == {2'h0, idx});
  endfunction : isReg

  function automatic logic isMapped(input logic [11:0] a);
    isMapped = isReg(a, `RTCS_IDX_CTRL1) || isReg(a, `RTCS_IDX_CTRL2) ||
               isReg(a, `RTCS_IDX_FLAGS) || isReg(a, `RTCS_IDX_ALM_MIN) ||
               isReg(a, `RTCS_IDX_ALM_HOUR) || isReg(a, `RTCS_IDX_SEC) ||
               isReg(a, `RTCS_IDX_MIN) || isReg(a, `RTCS_IDX_HOUR) ||
               isReg(a, `RTCS_IDX_DAY) || isReg(a, `RTCS_IDX_CHR);
  endfunction : isMapped

  // 001 is reserved; it gets the 000 divider limits rather than stopping the clock
  function automatic logic [14:0] quarterLimit(input logic [2:0] sel);
    if (sel[2]) begin
      quarterLimit = sel[0] ? `RTCS_Q_76800 : `RTCS_Q_64000;
    end else if (sel[1]) begin
      quarterLimit = sel[0] ? `RTCS_Q_38400 : `RTCS_Q_32000;
    end else begin
      quarterLimit = `RTCS_Q_32768;
    end
  endfunction : quarterLimit

  function automatic logic [9:0] chrLimit(input logic [2:0] sel);
    if (sel[2]) begin
      chrLimit = sel[0] ? `RTCS_C_76800 : `RTCS_C_64000;
    end else if (sel[1]) begin
      chrLimit = sel[0] ? `RTCS_C_38400 : `RTCS_C_32000;
    end else begin
      chrLimit = `RTCS_C_32768;
    end
  endfunction : chrLimit

  always_comb begin
    logic [13:0] scaled;
    scaled   = 14'h0;
    next_st  = st;
    setMask  = 8'h00;
    clrMask  = 8'h00;
    qTick    = 1'b0;
    cTick    = 1'b0;
    secTick  = 1'b0;
    minTick  = 1'b0;
    hourTick = 1'b0;
    dayTick  = 1'b0;
    wr8      = pwdata[7:0];

    // synchroniser; only the second stage feeds edge detection
    next_st.refSync1 = oscillatorRefClock;
    next_st.refSync2 = st.refSync1;
    next_st.refPrev  = st.refSync2;
    refEdge = st.refSync2 && !st.refPrev && st.modEn;

    if (refEdge) begin
      if (st.prescale >= quarterLimit(st.freqSel) - 15'h1) begin
        next_st.prescale = 15'h0;
        qTick = 1'b1;
      end else begin
        next_st.prescale = st.prescale + 15'h1;
      end
      if (st.chrEn) begin
        if (st.chrDiv >= chrLimit(st.freqSel) - 10'h1) begin
          next_st.chrDiv = 10'h0;
          cTick = 1'b1;
        end else begin
          next_st.chrDiv = st.chrDiv + 10'h1;
        end
      end
    end

    if (qTick) begin
      next_st.quarter = st.quarter + 2'h1;
      setMask[`RTCS_F_QUARTER] = 1'b1;
      setMask[`RTCS_F_HALF] = st.quarter[0];
      secTick = (st.quarter == 2'h3);
    end
    if (secTick) begin
      setMask[`RTCS_F_SEC] = 1'b1;
      if (st.sec == `RTCS_SEC_MAX) begin
        next_st.sec = 6'h0;
        minTick = 1'b1;
      end else begin
        next_st.sec = st.sec + 6'h1;
      end
    end
    if (minTick) begin
      setMask[`RTCS_F_MIN] = 1'b1;
      if (st.min == `RTCS_MIN_MAX) begin
        next_st.min = 6'h0;
        hourTick = 1'b1;
      end else begin
        next_st.min = st.min + 6'h1;
      end
    end
    if (hourTick) begin
      setMask[`RTCS_F_HOUR] = 1'b1;
      if (st.hour == `RTCS_HOUR_MAX) begin
        next_st.hour = 5'h0;
        dayTick = 1'b1;
      end else begin
        next_st.hour = st.hour + 5'h1;
      end
    end
    if (dayTick) begin
      setMask[`RTCS_F_DAY] = 1'b1;
      // month lengths are outside this block; the day wraps after 31
      next_st.day = (st.day >= `RTCS_DAY_MAX) ? `RTCS_DAY_RESET
                                              : st.day + 5'h1;
    end
    if (cTick) begin
      setMask[`RTCS_F_CHR] = 1'b1;
      if (st.freqSel == 3'h0) begin
        next_st.chrRaw = (st.chrRaw == `RTCS_RAW_WRAP_128) ? 7'h0
                                                           : st.chrRaw + 7'h1;
      end else begin
        next_st.chrRaw = (st.chrRaw >= `RTCS_RAW_WRAP_100) ? 7'h0
                                                           : st.chrRaw + 7'h1;
      end
      // 128 Hz counts become hundredths: raw * 100 / 128
      scaled = {7'h0, next_st.chrRaw} * 14'h19;
      next_st.chrData = (st.freqSel == 3'h0) ? scaled[11:5]
                                             : next_st.chrRaw;
    end

    // edge detected so a cleared alarm does not refire for the whole minute
    almMatch = ({2'h0, st.min} == st.almMin) &&
               ({3'h0, st.hour} == st.almHour);
    next_st.almHit = almMatch;
    setMask[`RTCS_F_ALM] = almMatch && !st.almHit;

    // apb: one wait state so read data and pready come from flip-flops
    apbFirst = psel && penable && !st.pready;
    apbDone  = psel && penable && st.pready;
    wrDone   = apbDone && pwrite;
    rdDone   = apbDone && !pwrite;
    next_st.pready  = apbFirst;
    next_st.pslverr = apbFirst && !isMapped(paddr);
    next_st.prdata  = 32'h0;
    if (apbFirst && !pwrite) begin
      if (isReg(paddr, `RTCS_IDX_CTRL1)) begin
        next_st.prdata = {24'h0, st.irqEn};
      end else if (isReg(paddr, `RTCS_IDX_CTRL2)) begin
        next_st.prdata = {24'h0, 1'b0, st.chrEn, st.modEn, 2'h0,
                          st.freqSel};
      end else if (isReg(paddr, `RTCS_IDX_FLAGS)) begin
        next_st.prdata = {24'h0, st.flags};
      end else if (isReg(paddr, `RTCS_IDX_ALM_MIN)) begin
        next_st.prdata = {24'h0, st.almMin};
      end else if (isReg(paddr, `RTCS_IDX_ALM_HOUR)) begin
        next_st.prdata = {24'h0, st.almHour};
      end else if (isReg(paddr, `RTCS_IDX_SEC)) begin
        next_st.prdata = {26'h0, st.sec};
      end else if (isReg(paddr, `RTCS_IDX_MIN)) begin
        next_st.prdata = {26'h0, st.min};
      end else if (isReg(paddr, `RTCS_IDX_HOUR)) begin
        next_st.prdata = {27'h0, st.hour};
      end else if (isReg(paddr, `RTCS_IDX_DAY)) begin
        next_st.prdata = {27'h0, st.day};
      end else if (isReg(paddr, `RTCS_IDX_CHR)) begin
        next_st.prdata = {25'h0, st.chrData};
      end else begin
        next_st.prdata = 32'h0;
      end
    end

    // writes land after the tick logic so a load wins over a same-cycle tick
    if (wrDone) begin
      if (isReg(paddr, `RTCS_IDX_CTRL1)) begin
        next_st.irqEn = wr8;
      end else if (isReg(paddr, `RTCS_IDX_CTRL2)) begin
        next_st.chrEn = wr8[`RTCS_C2_STOPWATCH_ENABLE];
        next_st.modEn = wr8[`RTCS_C2_MODE];
        if (!st.freqLocked) begin
          next_st.freqSel    = wr8[2:0];
          next_st.freqLocked = 1'b1;
        end
        if (wr8[`RTCS_C2_CLR]) begin
          next_st.chrRaw  = 7'h0;
          next_st.chrData = 7'h0;
          next_st.chrDiv  = 10'h0;
        end
      end else if (isReg(paddr, `RTCS_IDX_ALM_MIN)) begin
        next_st.almMin = wr8;
      end else if (isReg(paddr, `RTCS_IDX_ALM_HOUR)) begin
        next_st.almHour = wr8;
      end else if (isReg(paddr, `RTCS_IDX_SEC)) begin
        if (wr8 <= {2'h0, `RTCS_SEC_MAX}) begin
          next_st.sec = wr8[5:0];
        end
      end else if (isReg(paddr, `RTCS_IDX_MIN)) begin
        if (wr8 <= {2'h0, `RTCS_MIN_MAX}) begin
          next_st.min = wr8[5:0];
        end
      end else if (isReg(paddr, `RTCS_IDX_HOUR)) begin
        if (wr8 <= {3'h0, `RTCS_HOUR_MAX}) begin
          next_st.hour = wr8[4:0];
        end
      end else if (isReg(paddr, `RTCS_IDX_DAY)) begin
        if (wr8 >= {3'h0, `RTCS_DAY_RESET} &&
            wr8 <= {3'h0, `RTCS_DAY_MAX}) begin
          next_st.day = wr8[4:0];
        end
      end
    end

    // read-sequence clearing, limited to flags armed by the status read
    if (rdDone) begin
      if (isReg(paddr, `RTCS_IDX_ALM_HOUR)) begin
        clrMask[`RTCS_F_ALM] = st.armed[`RTCS_F_ALM];
      end else if (isReg(paddr, `RTCS_IDX_CHR)) begin
        clrMask[`RTCS_F_CHR]     = st.armed[`RTCS_F_CHR];
        clrMask[`RTCS_F_HALF]    = st.armed[`RTCS_F_HALF];
        clrMask[`RTCS_F_QUARTER] = st.armed[`RTCS_F_QUARTER];
      end else if (isReg(paddr, `RTCS_IDX_DAY)) begin
        clrMask[`RTCS_F_DAY] = st.armed[`RTCS_F_DAY];
      end else if (isReg(paddr, `RTCS_IDX_HOUR)) begin
        clrMask[`RTCS_F_HOUR] = st.armed[`RTCS_F_HOUR];
      end else if (isReg(paddr, `RTCS_IDX_MIN)) begin
        clrMask[`RTCS_F_MIN] = st.armed[`RTCS_F_MIN];
      end else if (isReg(paddr, `RTCS_IDX_SEC)) begin
        clrMask[`RTCS_F_SEC] = st.armed[`RTCS_F_SEC];
      end
    end
    if (rdDone && isReg(paddr, `RTCS_IDX_FLAGS)) begin
      next_st.armed = st.prdata[7:0];
    end else begin
      next_st.armed = st.armed & ~clrMask;
    end
    // a flag set in the same cycle as its clear stays set
    next_st.flags = (st.flags & ~clrMask) | setMask;
    next_st.irq   = |(next_st.flags & next_st.irqEn);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st         <= '0;
      st.day     <= `RTCS_DAY_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign pready  = st.pready;
  assign pslverr = st.pslverr;
  assign prdata  = st.prdata;
  assign irq     = st.irq;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_irq_matches_flags: assert property (
    irq == |(st.flags & st.irqEn))
    else $error("irq does not follow enabled flags");
  a_sec_range: assert property (
    st.sec <= `RTCS_SEC_MAX && st.min <= `RTCS_MIN_MAX)
    else $error("second or minute out of range");
  a_hour_range: assert property (
    st.hour <= `RTCS_HOUR_MAX)
    else $error("hour out of range");
  a_chr_range: assert property (
    st.chrData <= `RTCS_CHR_MAX)
    else $error("stopwatch data above 99");
  a_freq_write_once: assert property (
    st.freqLocked |=> st.freqLocked && st.freqSel == $past(st.freqSel))
    else $error("frequency select changed after first write");
  a_sec_bad_write: assert property (
    wrDone && isReg(paddr, `RTCS_IDX_SEC) && wr8 > {2'h0, `RTCS_SEC_MAX}
      && !secTick |=> $stable(st.sec))
    else $error("out of range second write altered counter");
  a_disabled_frozen: assert property (
    !st.modEn && !apbDone |=> $stable(st.sec) && $stable(st.chrData))
    else $error("counting while module disabled");
  a_chr_clear: assert property (
    wrDone && isReg(paddr, `RTCS_IDX_CTRL2) && wr8[`RTCS_C2_CLR]
      |=> st.chrData == 7'h0 && st.chrRaw == 7'h0)
    else $error("stopwatch clear did not zero counter");
  a_alarm_sets: assert property (
    almMatch && !st.almHit |=> st.flags[`RTCS_F_ALM])
    else $error("alarm flag missed a match");
  a_ready_single: assert property (
    st.pready |=> !st.pready)
    else $error("pready held more than one cycle");
  a_unarmed_kept: assert property (
    rdDone && isReg(paddr, `RTCS_IDX_SEC) && !st.armed[`RTCS_F_SEC]
      && st.flags[`RTCS_F_SEC] |=> st.flags[`RTCS_F_SEC])
    else $error("unarmed second flag was cleared");
  a_alarm_cleared: assert property (
    rdDone && isReg(paddr, `RTCS_IDX_ALM_HOUR) && st.armed[`RTCS_F_ALM]
      && !setMask[`RTCS_F_ALM] |=> !st.flags[`RTCS_F_ALM])
    else $error("armed alarm flag survived its clear");
  a_chr_hold: assert property (
    !st.chrEn && !apbDone |=> $stable(st.chrData))
    else $error("stopwatch moved while disabled");
  a_quarter_sets: assert property (
    qTick |=> st.flags[`RTCS_F_QUARTER])
    else $error("quarter second flag missed a tick");
  a_min_wrap: assert property (
    minTick && st.min == `RTCS_MIN_MAX && !apbDone |=> st.min == 6'h0)
    else $error("minute did not wrap after 59");

  c_alarm_flag: cover property (almMatch && !st.almHit);
  c_sec_wrap: cover property (secTick && st.sec == `RTCS_SEC_MAX);
  c_flag_cleared: cover property (|clrMask);
  c_fast_ref: cover property (cTick && st.freqSel[2]);
  c_chr_clear: cover property (
    wrDone && isReg(paddr, `RTCS_IDX_CTRL2) && wr8[`RTCS_C2_CLR]);

endmodule : rtcs_top

//--- tb_top.sv
`timescale 1ns/1ps
`include "rtcs_defs.svh"

module tb_top
  import rtcs_pkg::*;
;
  // clock, reset and reference pin
  logic        clk_sys;
  logic        rst_n;
  logic        oscillatorRefClock;
  // apb
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic        irq;
  int          n_errors;
  int          checked;

  rtcs_top DUT (
    .clk_sys            (clk_sys),
    .rst_n              (rst_n),
    .oscillatorRefClock (oscillatorRefClock),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .prdata             (prdata),
    .irq                (irq)
  );

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // reference runs at half the bus clock so a whole second fits the run
  // held low in reset so the edge detector sees no false edge on release
  always @(posedge clk_sys) begin
    oscillatorRefClock <= rst_n ? ~oscillatorRefClock : 1'b0;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("comparisons=%0d mismatches=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  function automatic logic [11:0] ad(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : ad

  // reference edges per hundredth of a second for the 100 Hz selects
  function automatic int chr_edges(input logic [2:0] sel);
    return (sel[2] ? (sel[0] ? 76800 : 64000)
                   : (sel[0] ? 38400 : 32000)) / 100;
  endfunction : chr_edges

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk(32'h0, 32'h1);
    end
    q       = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, ad(idx), {24'h0, d}, q, e);
  endtask : wr

  task automatic rd(input logic [7:0] idx, output logic [31:0] q);
    logic e;
    apb(1'b0, ad(idx), 32'h0, q, e);
  endtask : rd

  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
  endtask : wait_irq

  initial begin : watchdog
    repeat (90000) @(posedge clk_sys);
    n_errors++;
    final_report();
  end

  initial begin : main
    logic [31:0] q;
    logic [31:0] a;
    logic [31:0] b;
    logic        e;
    logic [7:0]  v;
    logic [7:0]  idx [4];
    int          bitPos [4];
    n_errors           = 0;
    checked            = 0;
    rst_n              = 1'b0;
    psel               = 1'b0;
    penable            = 1'b0;
    pwrite             = 1'b0;
    paddr              = 12'h000;
    pwdata             = 32'h0;
    void'($urandom(32'h66E99392));
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(`RTCS_IDX_CTRL2, q); chk(q, 32'h0);
    // 00:00 equals the cleared alarm registers, so the alarm flag rises
    rd(`RTCS_IDX_FLAGS, q); chk(q, 32'h80);
    rd(`RTCS_IDX_ALM_HOUR, q);
    rd(`RTCS_IDX_FLAGS, q); chk(q, 32'h0);
    rd(`RTCS_IDX_CHR, q); chk(q, 32'h0);
    apb(1'b0, 12'hFFC, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    // enable at 32.768 kHz, then a second select write must not stick
    wr(`RTCS_IDX_CTRL2, 8'h20);
    wr(`RTCS_IDX_CTRL2, 8'h27);
    rd(`RTCS_IDX_CTRL2, q); chk(q, 32'h20);
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      wr(`RTCS_IDX_ALM_MIN, v);
      rd(`RTCS_IDX_ALM_MIN, q); chk(q, {24'h0, v});
      v = 8'($urandom);
      wr(`RTCS_IDX_ALM_HOUR, v);
      rd(`RTCS_IDX_ALM_HOUR, q); chk(q, {24'h0, v});
    end
    // loads: corners 0 and 59 plus random, then an out-of-range write
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'h3B : 8'($urandom_range(0, 59));
      wr(`RTCS_IDX_SEC, v);
      rd(`RTCS_IDX_SEC, q); chk(q, {24'h0, v});
      wr(`RTCS_IDX_SEC, 8'($urandom_range(60, 255)));
      rd(`RTCS_IDX_SEC, q); chk(q, {24'h0, v});
      wr(`RTCS_IDX_MIN, v);
      rd(`RTCS_IDX_MIN, q); chk(q, {24'h0, v});
      wr(`RTCS_IDX_MIN, 8'($urandom_range(60, 255)));
      rd(`RTCS_IDX_MIN, q); chk(q, {24'h0, v});
    end
    // stopwatch runs, freezes, clears
    wr(`RTCS_IDX_CTRL2, 8'h60);
    repeat (3000) @(posedge clk_sys);
    rd(`RTCS_IDX_CHR, a);
    chk({31'h0, (a != 0) && (a <= 99)}, 32'h1);
    wr(`RTCS_IDX_CTRL2, 8'h20);
    rd(`RTCS_IDX_CHR, a);
    repeat (1500) @(posedge clk_sys);
    rd(`RTCS_IDX_CHR, b); chk(b, a);
    rd(`RTCS_IDX_SEC, a);
    wr(`RTCS_IDX_CTRL2, 8'hA0);
    rd(`RTCS_IDX_CHR, b); chk(b, 32'h0);
    rd(`RTCS_IDX_CTRL2, q); chk(q, 32'h20);
    rd(`RTCS_IDX_SEC, b); chk(b, a);
    // quarter second flag raises irq, cleared by status then data read
    wr(`RTCS_IDX_CTRL1, 8'h01);
    wait_irq(20000);
    chk({31'h0, irq}, 32'h1);
    rd(`RTCS_IDX_FLAGS, q); chk({31'h0, q[0]}, 32'h1);
    rd(`RTCS_IDX_CHR, q);
    rd(`RTCS_IDX_FLAGS, q); chk({31'h0, q[0]}, 32'h0);
    // 00:59:59 rolls to 01:00:00 and meets an alarm at 01:00
    wr(`RTCS_IDX_ALM_MIN, 8'h00);
    wr(`RTCS_IDX_ALM_HOUR, 8'h01);
    wr(`RTCS_IDX_MIN, 8'h3B);
    wr(`RTCS_IDX_SEC, 8'h3B);
    rd(`RTCS_IDX_FLAGS, q);
    rd(`RTCS_IDX_ALM_HOUR, q);
    rd(`RTCS_IDX_FLAGS, q); chk({31'h0, q[7]}, 32'h0);
    wr(`RTCS_IDX_CTRL1, 8'h04);
    wait_irq(70000);
    chk({31'h0, irq}, 32'h1);
    rd(`RTCS_IDX_FLAGS, q);
    chk(q & 32'h9C, 32'h9C);
    rd(`RTCS_IDX_SEC, q); chk(q, 32'h0);
    rd(`RTCS_IDX_MIN, q); chk(q, 32'h0);
    rd(`RTCS_IDX_HOUR, q); chk(q, 32'h1);
    idx = '{`RTCS_IDX_ALM_HOUR, `RTCS_IDX_MIN, `RTCS_IDX_HOUR, `RTCS_IDX_SEC};
    bitPos = '{7, 3, 4, 2};
    for (int i = 0; i < 4; i++) begin
      rd(`RTCS_IDX_FLAGS, q);
      rd(idx[i], q);
      rd(`RTCS_IDX_FLAGS, q);
      chk({31'h0, q[bitPos[i]]}, 32'h0);
    end
    chk({31'h0, irq}, 32'h0);
    // second reset unlocks the select; time a random 100 Hz select over 4002
    // cycles, which hold exactly 2001 reference rising edges
    rst_n <= 1'b0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(`RTCS_IDX_CTRL2, q); chk(q, 32'h0);
    v = {5'h0, 3'($urandom_range(2, 7))};
    wr(`RTCS_IDX_CTRL2, 8'h60 | v);
    repeat (4000) @(posedge clk_sys);
    rd(`RTCS_IDX_CHR, q); chk(q, 2001 / chr_edges(v[2:0]));
    rd(`RTCS_IDX_CTRL2, q); chk(q, {24'h0, 8'h60 | v});
    final_report();
  end
endmodule : tb_top
